// File: adc_cfg_pkg.sv
// constants, carriers and helpers shared by the serial configuration port
package adc_cfg_pkg;

    // --------------------------------------------------------------------
    // frame layout
    // --------------------------------------------------------------------
    localparam int HDR_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int ADDR_W = 10;
    localparam int HDR_RW_POS = 15;
    localparam int HDR_LEN_HI = 14;
    localparam int HDR_LEN_LO = 13;
    localparam int HDR_ID_HI = 12;
    localparam int HDR_ID_LO = 10;
    localparam int HDR_ADDR_HI = 9;
    localparam logic HDR_READ = 1'b1;
    localparam logic ID_TOP_BIT = 1'b0;
    localparam logic [1:0] LEN_STREAM = 2'b11;

    // --------------------------------------------------------------------
    // register map
    // --------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] MODE_REG_ADDR = 10'h000;
    localparam logic [ADDR_W-1:0] LAST_REG_ADDR = 10'h15D;
    localparam logic [ADDR_W-1:0] TOP_ADDR = 10'h3FF;
    localparam logic [7:0] MODE_DEFAULT = 8'h24;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int MODE_OFF_BIT = 7;
    localparam int MODE_LSB_BIT = 6;
    localparam int MODE_SRST_BIT = 5;
    localparam int MODE_STBY_BIT = 4;

    // --------------------------------------------------------------------
    // timing
    // --------------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int SCLK_MAX_HZ = 50_000_000;
    localparam int POR_WAIT_CYCLES = 1 << 20;

    // --------------------------------------------------------------------
    // carriers
    // --------------------------------------------------------------------
    typedef struct packed {
        logic deep_off;
        logic lsb_first;
        logic soft_rst_n;
        logic standby;
    } mode_t;

    typedef struct packed {
        mode_t mode;
        logic [1:0] strap;
    } link_cfg_t;

    typedef enum logic [3:0] {
        LINK_HEADER = 4'b0001,
        LINK_WRITE = 4'b0010,
        LINK_READ = 4'b0100,
        LINK_IDLE = 4'b1000
    } link_state_t;

    // either half of the mirrored byte may request a mode
    function automatic mode_t mode_from_byte(input logic [7:0] b);
        mode_t m;
        m.deep_off = b[MODE_OFF_BIT] | b[0];
        m.lsb_first = b[MODE_LSB_BIT] | b[1];
        m.soft_rst_n = b[MODE_SRST_BIT] & b[2];
        m.standby = b[MODE_STBY_BIT] | b[3];
        return m;
    endfunction

    function automatic logic [7:0] mode_to_byte(input mode_t m);
        return {m.deep_off, m.lsb_first, m.soft_rst_n, m.standby,
                m.standby, m.soft_rst_n, m.lsb_first, m.deep_off};
    endfunction

    localparam mode_t MODE_RESET = mode_from_byte(MODE_DEFAULT);

endpackage

// File: adc_serial_config_port.sv
// serial configuration port with mode register and power-mode controls
`timescale 1ns/10ps

module adc_serial_config_port
#(
    parameter int POR_WAIT = adc_cfg_pkg::POR_WAIT_CYCLES
)
(
    // system clock domain
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    // serial link
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_out,
    // pins
    input wire logic addr_strap_hi_in,
    input wire logic addr_strap_lo_in,
    input wire logic hw_reset_n_in,
    // mode and power controls
    output adc_cfg_pkg::mode_t mode_out,
    output logic reference_on_out,
    output logic internal_clock_on_out,
    output logic core_on_out,
    // calibration and status
    output logic cal_clear_out,
    output logic recal_start_out,
    output logic regs_ready_out
);
    import adc_cfg_pkg::*;

    localparam int POR_W = $clog2(POR_WAIT + 1);
    localparam int SYNC_W = 4;
    // reset pin stage idles high so no false rise follows a reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 4'h8;

    // --------------------------------------------------------------------
    // link domain signals
    // --------------------------------------------------------------------
    link_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [HDR_BITS-2:0] hdr_reg;
    logic [HDR_BITS-1:0] hdr_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_step;
    logic [1:0] len_reg;
    logic [1:0] byte_cnt_reg;
    logic last_byte;
    logic [7:0] rx_reg;
    logic [7:0] rx_next;
    logic [7:0] tx_reg;
    logic id_match;
    logic wr_fire;
    logic wr_toggle_reg;
    logic [7:0] wr_data_reg;
    link_cfg_t cfg_meta_reg;
    link_cfg_t cfg_link_reg;

    // --------------------------------------------------------------------
    // system domain signals
    // --------------------------------------------------------------------
    logic [SYNC_W-1:0] pin_s1_reg;
    logic [SYNC_W-1:0] pin_s2_reg;
    logic [SYNC_W-1:0] pin_s3_reg;
    logic [SYNC_W-1:0] pin_lvl_reg;
    logic [SYNC_W-1:0] pin_raw;
    logic hw_seen_reg;
    logic wr_seen_reg;
    logic wr_event;
    logic hw_rise;
    logic [POR_W-1:0] por_cnt_reg;
    logic por_done;
    mode_t mode_reg;
    mode_t mode_next;
    link_cfg_t cfg_sys;

    function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a,
                                             input mode_t m);
        logic [7:0] d;
        d = UNMAPPED_READ;
        if (a == MODE_REG_ADDR)
        begin
            d = mode_to_byte(m);
        end
        return d;
    endfunction

    // --------------------------------------------------------------------
    // link: header and byte decoding
    // --------------------------------------------------------------------
    assign hdr_next = {hdr_reg, sdio_in};
    assign id_match = hdr_next[HDR_ID_HI:HDR_ID_LO]
                      == {ID_TOP_BIT, cfg_link_reg.strap};
    // saturate rather than wrap so a long stream never lands on 0x00
    assign addr_step = (addr_reg == TOP_ADDR) ? addr_reg
                       : addr_reg + 10'h001;
    assign last_byte = (len_reg != LEN_STREAM)
                       && (byte_cnt_reg == len_reg);
    assign rx_next = cfg_link_reg.mode.lsb_first
                     ? {sdio_in, rx_reg[7:1]}
                     : {rx_reg[6:0], sdio_in};
    assign wr_fire = (state_reg == LINK_WRITE) && (bit_cnt_reg == 4'h7)
                     && (addr_reg == MODE_REG_ADDR);

    // chip select high holds the whole frame engine cleared
    always_ff @(posedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
        begin
            state_reg <= LINK_HEADER;
            bit_cnt_reg <= 4'h0;
            hdr_reg <= '0;
            addr_reg <= '0;
            len_reg <= 2'b00;
            byte_cnt_reg <= 2'b00;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
        end
        else
        begin
            case (state_reg)
                LINK_HEADER:
                begin
                    hdr_reg <= hdr_next[HDR_BITS-2:0];
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == 4'(HDR_BITS - 1))
                    begin
                        bit_cnt_reg <= 4'h0;
                        addr_reg <= hdr_next[HDR_ADDR_HI:0];
                        len_reg <= hdr_next[HDR_LEN_HI:HDR_LEN_LO];
                        if (!id_match)
                        begin
                            state_reg <= LINK_IDLE;
                        end
                        else if (hdr_next[HDR_RW_POS] == HDR_READ)
                        begin
                            state_reg <= LINK_READ;
                            tx_reg <= read_byte(hdr_next[HDR_ADDR_HI:0],
                                                cfg_link_reg.mode);
                        end
                        else
                        begin
                            state_reg <= LINK_WRITE;
                        end
                    end
                end
                LINK_WRITE:
                begin
                    rx_reg <= rx_next;
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == 4'h7)
                    begin
                        bit_cnt_reg <= 4'h0;
                        addr_reg <= addr_step;
                        byte_cnt_reg <= byte_cnt_reg + 2'b01;
                        if (last_byte)
                        begin
                            state_reg <= LINK_IDLE;
                        end
                    end
                end
                LINK_READ:
                begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == 4'h7)
                    begin
                        bit_cnt_reg <= 4'h0;
                        addr_reg <= addr_step;
                        tx_reg <= read_byte(addr_step, cfg_link_reg.mode);
                        byte_cnt_reg <= byte_cnt_reg + 2'b01;
                        if (last_byte)
                        begin
                            state_reg <= LINK_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_reg <= LINK_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------------
    // link: read data driver on the falling edge
    // --------------------------------------------------------------------
    always_ff @(negedge sclk_in or posedge cs_n_in)
    begin
        if (cs_n_in)
        begin
            sdio_oe_out <= 1'b0;
            sdio_out <= 1'b0;
        end
        else
        begin
            sdio_oe_out <= (state_reg == LINK_READ);
            if (cfg_link_reg.mode.lsb_first)
            begin
                sdio_out <= tx_reg[bit_cnt_reg[2:0]];
            end
            else
            begin
                sdio_out <= tx_reg[3'h7 - bit_cnt_reg[2:0]];
            end
        end
    end

    // --------------------------------------------------------------------
    // link: completed byte handed over to the system domain
    // --------------------------------------------------------------------
    // not cleared by chip select: a finished write must survive the frame end
    always_ff @(posedge sclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wr_toggle_reg <= 1'b0;
            wr_data_reg <= MODE_DEFAULT;
        end
        else if (wr_fire && !cs_n_in)
        begin
            wr_data_reg <= rx_next;
            wr_toggle_reg <= ~wr_toggle_reg;
        end
    end

    // configuration seen by the link; header edges give it time to settle
    always_ff @(posedge sclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cfg_meta_reg <= {MODE_RESET, 2'b00};
            cfg_link_reg <= {MODE_RESET, 2'b00};
        end
        else
        begin
            cfg_meta_reg <= cfg_sys;
            cfg_link_reg <= cfg_meta_reg;
        end
    end

    // --------------------------------------------------------------------
    // system: pin and crossing synchronisers
    // --------------------------------------------------------------------
    assign pin_raw = {hw_reset_n_in, addr_strap_hi_in, addr_strap_lo_in,
                      wr_toggle_reg};

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            pin_s1_reg <= SYNC_IDLE;
            pin_s2_reg <= SYNC_IDLE;
            pin_s3_reg <= SYNC_IDLE;
        end
        else if (clk_en_in)
        begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // a level moves only when the last two stages agree
    for (genvar i = 0; i < SYNC_W; i++)
    begin : g_filter
        always_ff @(posedge clk_in)
        begin
            if (reset_in)
            begin
                pin_lvl_reg[i] <= SYNC_IDLE[i];
            end
            else if (clk_en_in && (pin_s2_reg[i] == pin_s3_reg[i]))
            begin
                pin_lvl_reg[i] <= pin_s3_reg[i];
            end
        end
    end

    assign wr_event = pin_lvl_reg[0] != wr_seen_reg;
    assign hw_rise = pin_lvl_reg[3] && !hw_seen_reg;
    assign cfg_sys = {mode_reg, pin_lvl_reg[2:1]};

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            wr_seen_reg <= 1'b0;
            hw_seen_reg <= 1'b1;
        end
        else if (clk_en_in)
        begin
            wr_seen_reg <= pin_lvl_reg[0];
            hw_seen_reg <= pin_lvl_reg[3];
        end
    end

    // --------------------------------------------------------------------
    // system: power-on wait
    // --------------------------------------------------------------------
    assign por_done = !regs_ready_out
                      && (por_cnt_reg == POR_W'(POR_WAIT - 1));

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            por_cnt_reg <= '0;
            regs_ready_out <= 1'b0;
        end
        else if (clk_en_in && !regs_ready_out)
        begin
            por_cnt_reg <= por_cnt_reg + POR_W'(1);
            if (por_done)
            begin
                regs_ready_out <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------------
    // system: mode register
    // --------------------------------------------------------------------
    always_comb
    begin
        mode_next = mode_reg;
        if (!pin_lvl_reg[3] || por_done)
        begin
            mode_next = MODE_RESET;
        end
        else if (wr_event && regs_ready_out)
        begin
            mode_next = mode_from_byte(wr_data_reg);
        end
    end

    // only the mode register lives here; soft reset never reloads it
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            mode_reg <= MODE_RESET;
        end
        else if (clk_en_in)
        begin
            mode_reg <= mode_next;
        end
    end

    assign mode_out = mode_reg;

    // --------------------------------------------------------------------
    // system: power and calibration controls
    // --------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            reference_on_out <= 1'b0;
            internal_clock_on_out <= 1'b0;
            core_on_out <= 1'b0;
            cal_clear_out <= 1'b1;
            recal_start_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            reference_on_out <= !mode_next.deep_off;
            internal_clock_on_out <= !mode_next.deep_off;
            core_on_out <= !mode_next.deep_off
                           && !mode_next.standby;
            cal_clear_out <= !mode_next.soft_rst_n || !pin_lvl_reg[3]
                             || !regs_ready_out;
            recal_start_out <= por_done || hw_rise
                               || (!mode_reg.soft_rst_n
                                   && mode_next.soft_rst_n);
        end
    end

endmodule

// File: adc_serial_config_port_bench.sv
// self-checking bench for the serial configuration port
`timescale 1ns/10ps
module adc_serial_config_port_bench;
    import adc_cfg_pkg::*;
    logic clk, rst, cs_n, sclk, line, float_bit, h_d, h_en, done;
    logic dev_d, dev_oe, strap_hi, strap_lo, hw_n, en;
    logic ref_on, clk_on, core_on, cal_clr, recal, ready;
    mode_t mode;
    logic [31:0] res;
    logic [31:0] exp_q[$];
    logic [2:0] id;
    int n_fail, n_compared, cycles;
    integer seed;

    adc_serial_config_port #(.POR_WAIT(16)) u_adc_serial_config_port (
        .clk_in(clk), .reset_in(rst), .clk_en_in(en), .sclk_in(sclk),
        .cs_n_in(cs_n), .sdio_in(line), .sdio_out(dev_d),
        .sdio_oe_out(dev_oe), .addr_strap_hi_in(strap_hi),
        .addr_strap_lo_in(strap_lo), .hw_reset_n_in(hw_n), .mode_out(mode),
        .reference_on_out(ref_on), .internal_clock_on_out(clk_on),
        .core_on_out(core_on), .cal_clear_out(cal_clr),
        .recal_start_out(recal), .regs_ready_out(ready));

    cfg_host_model u_cfg_host_model (
        .sclk_out(sclk), .cs_n_out(cs_n), .sdio_drive_out(h_d),
        .sdio_en_out(h_en), .sdio_line_in(line), .dev_oe_in(dev_oe),
        .done_out(done), .result_out(res));

    // an undriven line must not look like a stable value
    assign line = dev_oe ? dev_d : (h_en ? h_d : float_bit);

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        float_bit <= ~float_bit;
        cycles++;
        if (cycles == 10000)
        begin
            n_fail++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [31:0] got,
                         input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // each frame notes its expected {driven bits, read bytes}
    always @(posedge done)
        check("frame", res, exp_q.pop_front());

    task automatic frame(input logic rw, input logic [1:0] len,
        input logic [2:0] fid, input logic [9:0] addr, input logic [23:0] wd,
        input int nbits, input logic lsb, input logic [31:0] exp);
        exp_q.push_back(exp);
        u_cfg_host_model.run({rw, len, fid, addr}, wd, nbits, lsb);
        repeat (12) @(negedge clk);
    endtask

    // {mode, reference, clock, core, cal clear}
    task automatic power(input logic [7:0] exp);
        check("power", {24'h00_0000, mode, ref_on, clk_on, core_on, cal_clr},
              {24'h00_0000, exp});
    endtask

    initial
    begin
        seed = 32'h5a3f_9343;
        rst = 1'b1;
        en = 1'b1;
        hw_n = 1'b1;
        float_bit = 1'b0;
        {strap_hi, strap_lo} = 2'($random(seed));
        id = {1'b0, strap_hi, strap_lo};
        repeat (2) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 100 && ready !== 1'b1; i++)
            @(negedge clk);
        repeat (10) @(negedge clk);
        power(8'h2E);
        for (int n = 0; n < 3; n++)
            frame(1'b1, 2'(n), id, 10'h000, 24'h00_0000, 32, 1'b0,
                  {8'(8 * n + 8), 24'h24_0000});
        // start near the top so a wrap to zero would read the mode byte
        frame(1'b1, 2'h3, id, {9'h1FF, 1'($random(seed))}, 24'h00_0000,
              24, 1'b0, 32'h1800_0000);
        for (int k = 0; k < 3; k++)
            frame(1'b1, 2'h0, id ^ (3'h1 << k), 10'h000, 24'h00_0000, 16,
                  1'b0, 32'h0000_0000);
        frame(1'b0, 2'h0, id, 10'h000, 24'hA5_0000, 8, 1'b0, 32'h0000_0000);
        power(8'hA0);
        frame(1'b1, 2'h0, id, 10'h000, 24'h00_0000, 8, 1'b0, 32'h08A5_0000);
        frame(1'b0, 2'h0, id, 10'h000, 24'h18_0000, 8, 1'b0, 32'h0000_0000);
        power(8'h1D);
        frame(1'b0, 2'h0, id, 10'h000, 24'h3C_0000, 8, 1'b0, 32'h0000_0000);
        power(8'h3C);
        frame(1'b0, 2'h0, id ^ 3'h4, 10'h000, 24'h24_0000, 8, 1'b0, 32'h0);
        frame(1'b0, 2'h0, id, 10'h000, 24'h24_0000, 5, 1'b0, 32'h0000_0000);
        power(8'h3C);
        frame(1'b0, 2'h3, id, 10'h000, 24'h24_A500, 16, 1'b0, 32'h0000_0000);
        power(8'h2E);
        frame(1'b0, 2'h0, id, 10'h000, 24'h66_0000, 8, 1'b0, 32'h0000_0000);
        power(8'h6E);
        frame(1'b1, 2'h1, id, 10'h000, 24'h00_0000, 16, 1'b1, 32'h1066_0000);
        frame(1'b0, 2'h0, id, 10'h000, 24'h80_0000, 8, 1'b1, 32'h0000_0000);
        power(8'h81);
        // a frozen system side must hold the write until enabled again
        en = 1'b0;
        frame(1'b0, 2'h0, id, 10'h000, 24'h3C_0000, 8, 1'b0, 32'h0000_0000);
        power(8'h81);
        en = 1'b1;
        repeat (12) @(negedge clk);
        power(8'h3C);
        hw_n = 1'b0;
        repeat (10) @(negedge clk);
        power(8'h2F);
        hw_n = 1'b1;
        repeat (12) @(negedge clk);
        power(8'h2E);
        finish_test();
    end
endmodule

// File: cfg_host_model.sv
// host controller model driving the serial configuration link
`timescale 1ns/10ps
module cfg_host_model
(
    // link
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdio_drive_out,
    output logic sdio_en_out,
    input wire logic sdio_line_in,
    input wire logic dev_oe_in,
    // result of the last frame: {bits seen driven, read bytes}
    output logic done_out,
    output logic [31:0] result_out
);
    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdio_drive_out = 1'b0;
        sdio_en_out = 1'b0;
        done_out = 1'b0;
        result_out = 32'h0000_0000;
    end

    // clock idles low and only runs inside a frame
    task automatic run(input logic [15:0] hdr, input logic [23:0] wd,
                       input int nbits, input logic lsb);
        int pos;
        logic [7:0] oe_cnt;
        logic [23:0] rd;
        oe_cnt = 8'h00;
        rd = 24'h00_0000;
        cs_n_out = 1'b0;
        for (int i = 0; i < 16 + nbits; i++)
        begin
            pos = 23 - 8 * ((i - 16) / 8) - (lsb ? 7 - i % 8 : i % 8);
            sdio_en_out = (i < 16) || !hdr[15];
            sdio_drive_out = (i < 16) ? hdr[15 - i] : wd[pos];
            #15 sclk_out = 1'b1;
            if (i >= 16 && dev_oe_in)
            begin
                oe_cnt++;
                rd[pos] = sdio_line_in;
            end
            #15 sclk_out = 1'b0;
        end
        #10 cs_n_out = 1'b1;
        sdio_en_out = 1'b0;
        #20 result_out = {oe_cnt, rd};
        done_out = 1'b1;
        #1 done_out = 1'b0;
    endtask
endmodule

// File: cfg_port_chk_sva.sv
// assertion checker for the serial configuration port
`timescale 1ns/10ps
module cfg_port_chk
    import adc_cfg_pkg::*;
#(
    parameter int POR_WAIT = 16
)
(
    // system side
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    // link
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe_out,
    // pins and controls
    input wire logic addr_strap_hi_in,
    input wire logic addr_strap_lo_in,
    input wire logic hw_reset_n_in,
    input wire mode_t mode_out,
    input wire logic reference_on_out,
    input wire logic internal_clock_on_out,
    input wire logic core_on_out,
    input wire logic cal_clear_out,
    input wire logic recal_start_out,
    input wire logic regs_ready_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [7:0] bit_cnt;
    logic [15:0] hdr;
    logic [7:0] data_end;
    logic id_ok;
    int por_cnt;

    assign data_end = 8'h18 + {3'h0, hdr[14:13], 3'h0};
    assign id_ok = hdr[12:10] == {1'b0, addr_strap_hi_in, addr_strap_lo_in};

    // counts saturate so a long stream cannot wrap into the header
    always_ff @(posedge sclk_in or posedge cs_n_in)
        if (cs_n_in)
            bit_cnt <= 8'h00;
        else if (bit_cnt != 8'hFF)
            bit_cnt <= bit_cnt + 8'h01;

    always_ff @(posedge sclk_in or posedge cs_n_in)
        if (cs_n_in)
            hdr <= 16'h0000;
        else if (bit_cnt < 8'h10)
            hdr <= {hdr[14:0], sdio_in};

    always_ff @(posedge clk_in)
        if (reset_in)
            por_cnt <= 0;
        else if (clk_en_in && por_cnt <= POR_WAIT)
            por_cnt <= por_cnt + 1;

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_idle; @(posedge clk_in) disable iff (reset_in)
        cs_n_in |-> !sdio_oe_out && !sdio_out;
    endproperty
    a_idle: assert property (p_idle)
        else $error("data line driven while deselected");
    property p_hdr_in; @(posedge sclk_in) disable iff (cs_n_in)
        bit_cnt < 8'h10 |-> !sdio_oe_out;
    endproperty
    a_hdr_in: assert property (p_hdr_in)
        else $error("data line driven during header");
    property p_turn; @(posedge sclk_in) disable iff (cs_n_in)
        $rose(sdio_oe_out) |-> bit_cnt == 8'h10 && hdr[15] && id_ok;
    endproperty
    a_turn: assert property (p_turn)
        else $error("read turnaround at wrong bit");
    property p_len; @(posedge sclk_in) disable iff (cs_n_in)
        bit_cnt >= data_end && hdr[14:13] != LEN_STREAM |-> !sdio_oe_out;
    endproperty
    a_len: assert property (p_len)
        else $error("read drive past byte count");
    property p_id; @(posedge sclk_in) disable iff (cs_n_in)
        bit_cnt >= 8'h10 && !(id_ok && hdr[15]) |-> !sdio_oe_out;
    endproperty
    a_id: assert property (p_id)
        else $error("drive on write or foreign id");
    property p_off; @(posedge clk_in) disable iff (reset_in)
        mode_out.deep_off |-> !(reference_on_out | internal_clock_on_out);
    endproperty
    a_off: assert property (p_off)
        else $error("reference or clock on in deep power-off");
    property p_stby; @(posedge clk_in) disable iff (reset_in)
        mode_out.standby && !mode_out.deep_off |->
        reference_on_out && internal_clock_on_out && !core_on_out;
    endproperty
    a_stby: assert property (p_stby)
        else $error("standby power state wrong");
    property p_recal; @(posedge clk_in) disable iff (reset_in)
        $rose(mode_out.soft_rst_n) && hw_reset_n_in |-> ##[0:2] recal_start_out;
    endproperty
    a_recal: assert property (p_recal)
        else $error("no recalibration after soft reset");
    property p_por; @(posedge clk_in) disable iff (reset_in)
        $rose(regs_ready_out) |-> por_cnt == POR_WAIT && mode_out == MODE_RESET;
    endproperty
    a_por: assert property (p_por)
        else $error("power-on load at wrong time or value");
    property p_hw; @(posedge clk_in) disable iff (reset_in)
        !hw_reset_n_in [*6] |-> mode_out == MODE_RESET && cal_clear_out;
    endproperty
    a_hw: assert property (p_hw)
        else $error("hardware reset pin did not restore defaults");

    c_read: cover property (@(posedge sclk_in) $rose(sdio_oe_out));
    c_recal: cover property (@(posedge clk_in) recal_start_out);
    c_off: cover property (@(posedge clk_in) mode_out.deep_off);
endmodule

bind adc_serial_config_port cfg_port_chk #(.POR_WAIT(POR_WAIT)) u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .sclk_in(sclk_in), .cs_n_in(cs_n_in), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out),
    .addr_strap_hi_in(addr_strap_hi_in), .addr_strap_lo_in(addr_strap_lo_in),
    .hw_reset_n_in(hw_reset_n_in), .mode_out(mode_out),
    .reference_on_out(reference_on_out), .core_on_out(core_on_out),
    .internal_clock_on_out(internal_clock_on_out),
    .cal_clear_out(cal_clear_out), .recal_start_out(recal_start_out),
    .regs_ready_out(regs_ready_out));
